// >>> design/dio_pkg.sv
package dio_pkg;

    // Clock and microsecond ticker
    localparam int CLK_PERIOD_NS  = 50;
    localparam int TICK_PERIOD_NS = 1000;
    localparam int TICK_DIV       = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [4:0] TICK_LAST = 5'(TICK_DIV - 1);

    // Parameter byte values
    localparam logic [7:0] DIAG_DISABLE = 8'h00;
    localparam logic [7:0] DIAG_ENABLE  = 8'h40;

    // Record numbers
    localparam logic [7:0] REC_PARAM = 8'h00;
    localparam logic [7:0] REC_DIAG  = 8'h01;

    // Record geometry and byte positions
    localparam int         REC_DEPTH     = 20;
    localparam logic [4:0] REC_LEN       = 5'h14;
    localparam logic [4:0] REC_SHORT_LEN = 5'h04;
    localparam logic [4:0] REC_LAST      = 5'h13;
    localparam logic [4:0] IDX_SUMMARY   = 5'h00;
    localparam logic [4:0] IDX_MODCLASS  = 5'h01;
    localparam logic [4:0] IDX_CHTYPE    = 5'h04;
    localparam logic [4:0] IDX_TS0       = 5'h10;
    localparam logic [4:0] IDX_TS1       = 5'h11;
    localparam logic [4:0] IDX_TS2       = 5'h12;
    localparam logic [4:0] IDX_TS3       = 5'h13;

    // Fixed record contents
    localparam logic [7:0] MODCLASS_VAL = 8'h1F;
    localparam logic [7:0] CHTYPE_VAL   = 8'h72;
    localparam logic [7:0] RESERVED_VAL = 8'h00;

    // Summary byte bit positions
    localparam int SUM_FAIL_BIT = 0;
    localparam int SUM_INT_BIT  = 1;
    localparam int SUM_EXT_BIT  = 2;
    localparam int SUM_OVL_BIT  = 4;
    localparam int SUM_PRM_BIT  = 7;

    // Output image byte offsets
    localparam logic IMG_LOW  = 1'b0;
    localparam logic IMG_HIGH = 1'b1;

    // Cyclic input data size
    localparam logic [7:0] INPUT_BYTES = 8'h00;

    typedef enum logic [0:0] {
        ST_IDLE  = 1'b0,
        ST_WRITE = 1'b1
    } fsm_t;

endpackage : dio_pkg

// >>> design/diag_record_mem.sv
`timescale 1ns/100ps
module diag_record_mem #(
    parameter int DEPTH = 20,
    parameter int AW    = 5
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          sys_rst,
    // Write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    // Read port
    input  wire logic          re,
    input  wire logic [AW-1:0] raddr,
    output logic      [7:0]    rdata
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata <= 8'h00;
        end else if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule : diag_record_mem

// >>> design/do16_diag_record_and_output_image.sv
// Functional notes
// - Parameter 00h disables diagnostics and interrupt, 40h enables them. Load supply edges still raise interrupts under 00h.
// - Enabled diagnostics: first cause after none raises incoming interrupt, record becomes readable.
// - When all causes vanish, going interrupt is raised automatically.
// - Record 01h reads all 20 bytes; record 00h reads first four.
// - Summary bit 0 module failure, bit 1 internal, bit 2 external error.
// - Summary bit 4 output overload, bit 7 parameter error; 3,5,6 reserved.
// - Module class byte reads 1Fh, low nibble 1111b digital.
// - Channel type byte reads 72h, digital output.
// - Timestamp bytes hold ticker value captured at the diagnostic event.
// - Ticker starts at 0, counts microseconds, wraps after 32-bit maximum.
// - Reserved record bytes always read 00h.
// - Load supply switching on or off produces a diagnostic message.
// - Module supplies no cyclic input bytes.
// - Two-byte output image at +0 drives channels 0 to 15.
// - Channel indicator lit exactly while its output is commanded 1.
// - Module fault indicator on for overload, short circuit or overheat.
`timescale 1ns/100ps
module do16_diag_record_and_output_image (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Output image writes
    input  wire logic        img_wr,
    input  wire logic        img_addr,
    input  wire logic [7:0]  img_wdata,
    // Parameter record writes
    input  wire logic        prm_wr,
    input  wire logic [7:0]  prm_record_number,
    input  wire logic [7:0]  prm_wdata,
    // Diagnostic record reads
    input  wire logic        rd_req,
    input  wire logic [7:0]  rd_record_number,
    input  wire logic [4:0]  rd_byte_index,
    output logic             rd_ready,
    output logic             rd_valid,
    output logic             rd_error,
    output logic      [7:0]  rd_data,
    // Fault sources
    input  wire logic        module_failure,
    input  wire logic        internal_error,
    input  wire logic        load_supply_ok,
    input  wire logic        out_overload,
    input  wire logic        out_short,
    input  wire logic        out_overheat,
    // Channel outputs and indicators
    output logic      [15:0] chan_out,
    output logic      [15:0] chan_led,
    output logic             module_fault_indicator,
    // Diagnostic interrupts and status
    output logic             diag_irq_incoming,
    output logic             diag_irq_going,
    output logic             diag_active,
    output logic      [31:0] us_ticker,
    output logic      [7:0]  in_image_bytes
);
    typedef struct packed {
        dio_pkg::fsm_t fsm;
        logic [4:0]    wr_idx;
        logic [7:0]    img_lo;
        logic [7:0]    img_hi;
        logic [7:0]    diag_enable_param;
        logic          prm_err;
        logic [7:0]    sum_cap;
        logic [31:0]   ts_cap;
        logic [31:0]   ticker;
        logic [4:0]    presc;
        logic          pend_in;
        logic          pend_go;
        logic          irq_in;
        logic          irq_go;
        logic          fault_ind;
        logic          rd_valid;
        logic          rd_err;
        logic          rd_ready;
        logic          active;
    } state_t;

    // Reset starts by filling the record so constants read back at once
    localparam state_t RST_ST = '{fsm: dio_pkg::ST_WRITE, default: '0};

    state_t     st_reg;
    state_t     st_next;
    logic [7:0] cur_sum;
    logic       enabled;
    logic       fault_any;
    logic       trig;
    logic       rd_ok;
    logic       mem_we;
    logic [4:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic       mem_re;
    logic [4:0] mem_raddr;

    function automatic logic [7:0] rec_byte(input logic [4:0]  idx,
                                            input logic [7:0]  sum,
                                            input logic [31:0] ts);
        case (idx)
            dio_pkg::IDX_SUMMARY:  rec_byte = sum;
            dio_pkg::IDX_MODCLASS: rec_byte = dio_pkg::MODCLASS_VAL;
            dio_pkg::IDX_CHTYPE:   rec_byte = dio_pkg::CHTYPE_VAL;
            dio_pkg::IDX_TS0:      rec_byte = ts[31:24];
            dio_pkg::IDX_TS1:      rec_byte = ts[23:16];
            dio_pkg::IDX_TS2:      rec_byte = ts[15:8];
            dio_pkg::IDX_TS3:      rec_byte = ts[7:0];
            default:               rec_byte = dio_pkg::RESERVED_VAL;
        endcase
    endfunction : rec_byte

    assign enabled   = st_reg.diag_enable_param == dio_pkg::DIAG_ENABLE;
    assign fault_any = out_overload | out_short | out_overheat;

    always_comb begin
        cur_sum = 8'h00;
        cur_sum[dio_pkg::SUM_FAIL_BIT] = module_failure;
        cur_sum[dio_pkg::SUM_INT_BIT]  = internal_error;
        cur_sum[dio_pkg::SUM_EXT_BIT]  = !load_supply_ok;
        cur_sum[dio_pkg::SUM_OVL_BIT]  = fault_any;
        cur_sum[dio_pkg::SUM_PRM_BIT]  = st_reg.prm_err;
    end

    // Supply edges report even with diagnostics off
    assign trig = (enabled && cur_sum != st_reg.sum_cap) ||
                  (cur_sum[dio_pkg::SUM_EXT_BIT] != st_reg.sum_cap[dio_pkg::SUM_EXT_BIT]);

    assign rd_ok = (rd_record_number == dio_pkg::REC_DIAG && rd_byte_index < dio_pkg::REC_LEN) ||
                   (rd_record_number == dio_pkg::REC_PARAM &&
                    rd_byte_index < dio_pkg::REC_SHORT_LEN);

    always_comb begin
        st_next   = st_reg;
        mem_we    = 1'b0;
        mem_waddr = st_reg.wr_idx;
        mem_wdata = dio_pkg::RESERVED_VAL;
        mem_re    = 1'b0;
        mem_raddr = rd_byte_index;
        st_next.irq_in   = 1'b0;
        st_next.irq_go   = 1'b0;
        st_next.rd_valid = 1'b0;
        st_next.rd_err   = 1'b0;

        // Prescaled ticker, independent of bus traffic
        if (st_reg.presc == dio_pkg::TICK_LAST) begin
            st_next.presc  = 5'h00;
            st_next.ticker = st_reg.ticker + 32'h1;
        end else begin
            st_next.presc = st_reg.presc + 5'h01;
        end

        st_next.fault_ind = fault_any;

        if (img_wr) begin
            if (img_addr == dio_pkg::IMG_LOW) begin
                st_next.img_lo = img_wdata;
            end else begin
                st_next.img_hi = img_wdata;
            end
        end

        // Any value other than the two codes is flagged as bad parameter
        if (prm_wr && prm_record_number == dio_pkg::REC_PARAM) begin
            st_next.diag_enable_param = prm_wdata;
            st_next.prm_err = !(prm_wdata == dio_pkg::DIAG_DISABLE ||
                                prm_wdata == dio_pkg::DIAG_ENABLE);
        end

        if (rd_req && st_reg.rd_ready) begin
            mem_re           = rd_ok;
            st_next.rd_valid = rd_ok;
            st_next.rd_err   = !rd_ok;
        end

        case (st_reg.fsm)
            dio_pkg::ST_IDLE: begin
                if (trig) begin
                    st_next.fsm      = dio_pkg::ST_WRITE;
                    st_next.wr_idx   = 5'h00;
                    st_next.ts_cap   = st_reg.ticker;
                    st_next.sum_cap  = cur_sum;
                    st_next.pend_in  = st_reg.sum_cap == 8'h00 && cur_sum != 8'h00;
                    st_next.pend_go  = st_reg.sum_cap != 8'h00 && cur_sum == 8'h00;
                    st_next.rd_ready = 1'b0;
                end
            end
            dio_pkg::ST_WRITE: begin
                // Reads are held off so a record is never seen half updated
                mem_we    = 1'b1;
                mem_wdata = rec_byte(st_reg.wr_idx, st_reg.sum_cap, st_reg.ts_cap);
                if (st_reg.wr_idx == dio_pkg::REC_LAST) begin
                    st_next.fsm      = dio_pkg::ST_IDLE;
                    st_next.rd_ready = 1'b1;
                    st_next.irq_in   = st_reg.pend_in;
                    st_next.irq_go   = st_reg.pend_go;
                    st_next.active   = st_reg.sum_cap != 8'h00;
                    st_next.pend_in  = 1'b0;
                    st_next.pend_go  = 1'b0;
                end else begin
                    st_next.wr_idx = st_reg.wr_idx + 5'h01;
                end
            end
            default: begin
                st_next.fsm = dio_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= RST_ST;
        end else begin
            st_reg <= st_next;
        end
    end

    diag_record_mem #(
        .DEPTH (dio_pkg::REC_DEPTH),
        .AW    (5)
    ) u_record (
        .clk     (clk),
        .sys_rst (sys_rst),
        .we      (mem_we),
        .waddr   (mem_waddr),
        .wdata   (mem_wdata),
        .re      (mem_re),
        .raddr   (mem_raddr),
        .rdata   (rd_data)
    );

    assign rd_ready               = st_reg.rd_ready;
    assign rd_valid               = st_reg.rd_valid;
    assign rd_error               = st_reg.rd_err;
    assign chan_out               = {st_reg.img_hi, st_reg.img_lo};
    assign chan_led               = {st_reg.img_hi, st_reg.img_lo};
    assign module_fault_indicator = st_reg.fault_ind;
    assign diag_irq_incoming      = st_reg.irq_in;
    assign diag_irq_going         = st_reg.irq_go;
    assign diag_active            = st_reg.active;
    assign us_ticker              = st_reg.ticker;
    assign in_image_bytes         = dio_pkg::INPUT_BYTES;

    chk_tick_advance: assert property (
        @(posedge clk) disable iff (sys_rst)
        st_reg.presc == dio_pkg::TICK_LAST |=> st_reg.ticker == $past(st_reg.ticker) + 32'h1
    ) else $error("ticker did not advance at prescaler end");

    chk_tick_hold: assert property (
        @(posedge clk) disable iff (sys_rst)
        st_reg.presc != dio_pkg::TICK_LAST |=> $stable(st_reg.ticker)
    ) else $error("ticker moved between microsecond ticks");

    chk_incoming_irq: assert property (
        @(posedge clk) disable iff (sys_rst)
        (st_reg.fsm == dio_pkg::ST_IDLE && enabled && st_reg.sum_cap == 8'h00 &&
         cur_sum != 8'h00) |-> ##21 (diag_irq_incoming && rd_ready)
    ) else $error("incoming interrupt missing after new cause");

    chk_going_irq: assert property (
        @(posedge clk) disable iff (sys_rst)
        (st_reg.fsm == dio_pkg::ST_IDLE && enabled && st_reg.sum_cap != 8'h00 &&
         cur_sum == 8'h00) |-> ##21 (diag_irq_going && !diag_active)
    ) else $error("going interrupt missing after causes cleared");

    chk_param_enable: assert property (
        @(posedge clk) disable iff (sys_rst)
        (prm_wr && prm_record_number == dio_pkg::REC_PARAM) |=>
        (enabled == ($past(prm_wdata) == dio_pkg::DIAG_ENABLE))
    ) else $error("diagnostic enable does not follow parameter");

    chk_param_error: assert property (
        @(posedge clk) disable iff (sys_rst)
        (prm_wr && prm_record_number == dio_pkg::REC_PARAM &&
         prm_wdata != dio_pkg::DIAG_DISABLE && prm_wdata != dio_pkg::DIAG_ENABLE) |=>
        cur_sum[dio_pkg::SUM_PRM_BIT]
    ) else $error("bad parameter not flagged");

    chk_summary_bits: assert property (
        @(posedge clk) disable iff (sys_rst)
        (st_reg.fsm == dio_pkg::ST_IDLE && trig) |=>
        st_reg.sum_cap == {$past(st_reg.prm_err), 2'h0, $past(fault_any), 1'b0,
                           !$past(load_supply_ok), $past(internal_error), $past(module_failure)}
    ) else $error("summary byte does not match causes");

    chk_read_answer: assert property (
        @(posedge clk) disable iff (sys_rst)
        (rd_req && rd_ready && rd_record_number == dio_pkg::REC_DIAG &&
         rd_byte_index < dio_pkg::REC_LEN) |=> (rd_valid && !rd_error)
    ) else $error("full record read not answered");

    chk_fault_led: assert property (
        @(posedge clk) disable iff (sys_rst)
        1'b1 |=> module_fault_indicator == $past(fault_any)
    ) else $error("module fault indicator wrong");

    chk_image_low: assert property (
        @(posedge clk) disable iff (sys_rst)
        (img_wr && img_addr == dio_pkg::IMG_LOW) |=>
        (chan_out[7:0] == $past(img_wdata) && chan_led == chan_out)
    ) else $error("output image low byte not applied");

    chk_short_record: assert property (
        @(posedge clk) disable iff (sys_rst)
        (rd_req && rd_ready && rd_record_number == dio_pkg::REC_PARAM &&
         rd_byte_index >= dio_pkg::REC_SHORT_LEN) |=> (rd_error && !rd_valid)
    ) else $error("short record read beyond four bytes");

    chk_const_bytes: assert property (
        @(posedge clk) disable iff (sys_rst)
        (mem_we && mem_waddr == dio_pkg::IDX_MODCLASS) |-> mem_wdata == dio_pkg::MODCLASS_VAL
    ) else $error("module class byte wrong");

    chk_chtype_byte: assert property (
        @(posedge clk) disable iff (sys_rst)
        (mem_we && mem_waddr == dio_pkg::IDX_CHTYPE) |-> mem_wdata == dio_pkg::CHTYPE_VAL
    ) else $error("channel type byte wrong");

    chk_reserved_bytes: assert property (
        @(posedge clk) disable iff (sys_rst)
        (mem_we && mem_waddr > dio_pkg::IDX_MODCLASS && mem_waddr < dio_pkg::IDX_TS0 &&
         mem_waddr != dio_pkg::IDX_CHTYPE) |-> mem_wdata == dio_pkg::RESERVED_VAL
    ) else $error("reserved byte not zero");

    chk_stamp_capture: assert property (
        @(posedge clk) disable iff (sys_rst)
        (st_reg.fsm == dio_pkg::ST_IDLE && trig) |=>
        (st_reg.ts_cap == $past(st_reg.ticker)) ##16 (mem_wdata == st_reg.ts_cap[31:24])
    ) else $error("timestamp not captured at event");

    chk_supply_event: assert property (
        @(posedge clk) disable iff (sys_rst)
        (st_reg.fsm == dio_pkg::ST_IDLE &&
         load_supply_ok == st_reg.sum_cap[dio_pkg::SUM_EXT_BIT]) |=>
        st_reg.fsm == dio_pkg::ST_WRITE
    ) else $error("supply switching produced no message");

    chk_no_inputs: assert property (
        @(posedge clk) disable iff (sys_rst)
        in_image_bytes == dio_pkg::INPUT_BYTES && in_image_bytes == 8'h00
    ) else $error("input image size not zero");

endmodule : do16_diag_record_and_output_image

// >>> tb/bus_controller_model.sv
`timescale 1ns/100ps
module bus_controller_model (
    // Clock
    input  wire logic       clk,
    // Image and parameter writes
    output logic            img_wr,
    output logic            img_addr,
    output logic [7:0]      img_wdata,
    output logic            prm_wr,
    output logic [7:0]      prm_record_number,
    output logic [7:0]      prm_wdata,
    // Record reads
    output logic            rd_req,
    output logic [7:0]      rd_record_number,
    output logic [4:0]      rd_byte_index,
    input  wire logic       rd_ready,
    input  wire logic       rd_valid,
    input  wire logic       rd_error,
    input  wire logic [7:0] rd_data
);
    initial begin
        img_wr = 1'b0;
        img_addr = 1'b0;
        img_wdata = 8'h00;
        prm_wr = 1'b0;
        prm_record_number = 8'hFF;
        prm_wdata = 8'h00;
        rd_req = 1'b0;
        rd_record_number = 8'hFF;
        rd_byte_index = 5'h1F;
    end

    // Released data line shows the inverse, never a stale value; img_addr keeps its last value
    task automatic img_write(input logic a, input logic [7:0] d);
        @(negedge clk);
        img_wr = 1'b1;
        img_addr = a;
        img_wdata = d;
        @(negedge clk);
        img_wr = 1'b0;
        img_wdata = ~d;
    endtask : img_write

    // Caller only sends this while the system is stopped
    task automatic prm_write(input logic [7:0] no, input logic [7:0] d);
        @(negedge clk);
        prm_wr = 1'b1;
        prm_record_number = no;
        prm_wdata = d;
        @(negedge clk);
        prm_wr = 1'b0;
        prm_wdata = ~d;
    endtask : prm_write

    task automatic rd_byte(input logic [7:0] no, input logic [4:0] idx,
                           output logic [7:0] data, output logic valid,
                           output logic err, output logic ok);
        ok = 1'b0;
        for (int i = 0; i < 40 && !ok; i++) begin
            @(negedge clk);
            ok = (rd_ready === 1'b1);
        end
        if (ok) begin
            rd_req = 1'b1;
            rd_record_number = no;
            rd_byte_index = idx;
            @(negedge clk);
            rd_req = 1'b0;
            rd_byte_index = ~idx;
            data = rd_data;
            valid = rd_valid;
            err = rd_error;
        end
    endtask : rd_byte
endmodule : bus_controller_model

// >>> tb/test_do16_diag_record_and_output_image.sv
`timescale 1ns/100ps
module test_do16_diag_record_and_output_image;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        module_failure = 1'b0;
    logic        internal_error = 1'b0;
    logic        load_supply_ok = 1'b1;
    logic        out_overload = 1'b0;
    logic        out_short = 1'b0;
    logic        out_overheat = 1'b0;
    logic        img_wr, img_addr, prm_wr, rd_req, rd_ready, rd_valid, rd_error;
    logic [7:0]  img_wdata, prm_record_number, prm_wdata, rd_record_number, rd_data;
    logic [4:0]  rd_byte_index;
    logic [15:0] chan_out, chan_led;
    logic        module_fault_indicator, diag_irq_incoming, diag_irq_going, diag_active;
    logic [31:0] us_ticker, t0, ts;
    logic [7:0]  in_image_bytes, d;
    logic        v, e, ok;
    int          bad_count = 0;
    int          checks = 0;

    do16_diag_record_and_output_image do16_diag_record_and_output_image_inst (.*);
    bus_controller_model bus_controller_model_inst (.*);

    initial begin
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    task automatic rd(input logic [7:0] no, input logic [4:0] idx);
        bus_controller_model_inst.rd_byte(no, idx, d, v, e, ok);
        check(ok, 1'b1);
        if (!ok)
            end_of_test();
    endtask : rd

    task automatic rd_good(input logic [7:0] no, input logic [4:0] idx, input logic [7:0] x);
        rd(no, idx);
        check({v, e, d}, {2'b10, x});
    endtask : rd_good

    task automatic rd_bad(input logic [7:0] no, input logic [4:0] idx);
        rd(no, idx);
        check({v, e}, 2'b01);
    endtask : rd_bad

    // Bounded wait for one interrupt pulse
    task automatic wait_irq(input logic going);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 60 && !hit; i++) begin
            @(negedge clk);
            hit = going ? (diag_irq_going === 1'b1) : (diag_irq_incoming === 1'b1);
        end
        check(hit, 1'b1);
        if (!hit)
            end_of_test();
    endtask : wait_irq

    task automatic read_ts();
        for (int i = 0; i < 4; i++) begin
            rd(dio_pkg::REC_DIAG, 5'(16 + i));
            ts = {ts[23:0], d};
        end
    endtask : read_ts

    initial begin
        repeat (8) @(negedge clk);
        check(us_ticker, 32'h0000_0000);
        sys_rst = 1'b0;
        check(chan_out, 16'h0000);
        check(in_image_bytes, 8'h00);
        for (int i = 0; i < 16; i++) begin
            if (i == 1)
                rd_good(dio_pkg::REC_DIAG, 5'(i), 8'h1F);
            else if (i == 4)
                rd_good(dio_pkg::REC_DIAG, 5'(i), 8'h72);
            else
                rd_good(dio_pkg::REC_DIAG, 5'(i), 8'h00);
        end
        rd_good(dio_pkg::REC_PARAM, 5'h03, 8'h00);
        rd_good(dio_pkg::REC_PARAM, 5'h01, 8'h1F);
        rd_bad(dio_pkg::REC_PARAM, 5'h04);
        rd_bad(dio_pkg::REC_DIAG, 5'h14);
        rd_bad(8'h02, 5'h00);
        // Ticker step after exactly one prescaler period
        t0 = us_ticker;
        for (int i = 0; i < dio_pkg::TICK_DIV + 2 && us_ticker == t0; i++)
            @(negedge clk);
        t0 = us_ticker;
        repeat (dio_pkg::TICK_DIV - 1) @(negedge clk);
        check(us_ticker, t0);
        @(negedge clk);
        check(us_ticker, t0 + 32'h1);
        bus_controller_model_inst.img_write(dio_pkg::IMG_LOW, 8'hA5);
        bus_controller_model_inst.img_write(dio_pkg::IMG_HIGH, 8'h3C);
        check(chan_out, 16'h3CA5);
        check(chan_led, 16'h3CA5);
        bus_controller_model_inst.img_write(dio_pkg::IMG_LOW, 8'h00);
        check(chan_led, 16'h3C00);
        // Each output fault lights the module fault indicator
        for (int k = 0; k < 3; k++) begin
            {out_overheat, out_short, out_overload} = 3'(1 << k);
            @(negedge clk);
            @(negedge clk);
            check(module_fault_indicator, 1'b1);
            {out_overheat, out_short, out_overload} = 3'b000;
            @(negedge clk);
            @(negedge clk);
            check(module_fault_indicator, 1'b0);
        end
        // Disabled: an overload raises no interrupt
        out_overload = 1'b1;
        for (int i = 0; i < 40; i++) begin
            @(negedge clk);
            check(diag_irq_incoming, 1'b0);
        end
        t0 = us_ticker;
        bus_controller_model_inst.prm_write(dio_pkg::REC_PARAM, 8'h40);
        wait_irq(1'b0);
        check(diag_active, 1'b1);
        rd_good(dio_pkg::REC_DIAG, 5'h00, 8'h10);
        read_ts();
        check(ts >= t0 && ts <= us_ticker, 1'b1);
        // Parameter sent under a foreign record number is ignored
        bus_controller_model_inst.prm_write(8'h01, 8'h00);
        out_overload = 1'b0;
        wait_irq(1'b1);
        check(diag_active, 1'b0);
        rd_good(dio_pkg::REC_PARAM, 5'h00, 8'h00);
        module_failure = 1'b1;
        internal_error = 1'b1;
        wait_irq(1'b0);
        rd_good(dio_pkg::REC_DIAG, 5'h00, 8'h03);
        module_failure = 1'b0;
        internal_error = 1'b0;
        wait_irq(1'b1);
        // Supply switching reports even with diagnostics off; a bad code disables too
        bus_controller_model_inst.prm_write(dio_pkg::REC_PARAM, 8'h23);
        load_supply_ok = 1'b0;
        wait_irq(1'b0);
        rd_good(dio_pkg::REC_DIAG, 5'h00, 8'h84);
        bus_controller_model_inst.prm_write(dio_pkg::REC_PARAM, 8'h00);
        load_supply_ok = 1'b1;
        wait_irq(1'b1);
        rd_good(dio_pkg::REC_DIAG, 5'h00, 8'h00);
        end_of_test();
    end
endmodule : test_do16_diag_record_and_output_image
